// ### hw/tmoe_pkg.sv
// Purpose: Shared constants for the timing output enable register bank
// Assumes: 16-bit parallel register port on the device clock
// Notes: Offsets are word addresses on the parallel port
package tmoe_pkg;
  localparam int DATA_W = 16;
  localparam int ADDR_W = 14;
  localparam logic [ADDR_W-1:0] SW_RESET_CTRL_ADDR = 14'h0002;
  localparam logic [ADDR_W-1:0] TIMING_OUT_EN_ADDR = 14'h0003;
  localparam logic [DATA_W-1:0] SW_RESET_CTRL_RST = 16'h0000;
  localparam logic [DATA_W-1:0] TIMING_OUT_EN_RST = 16'h0000;
  // Field positions
  localparam int SWITCH_SOFT_RESET_BIT = 1;
  localparam int CLK_PULSE_PAIR0_DRIVE_EN = 0;
  localparam int CLK_PULSE_PAIR_CNT = 4;
  localparam int OFFSET_PULSE0_DRIVE_EN = 6;
  localparam int OFFSET_PULSE1_DRIVE_EN = 7;
  localparam int OFFSET_PULSE2_DRIVE_EN = 8;
  localparam int OFFSET_PULSE_CNT = 3;
  // Writable bits; reserved bits hold zero and read zero
  localparam logic [DATA_W-1:0] SW_RESET_CTRL_MASK = 16'h0002;
  localparam logic [DATA_W-1:0] TIMING_OUT_EN_MASK = 16'h01cf;
endpackage : tmoe_pkg

// ### hw/tmoe_pin_if.sv
// Purpose: Carries pin values and drive enables to the pin stage
// Assumes: One instance per group of output-only pins
// Notes: Output enable high means the pin is driven
`timescale 1ns/10ps
`default_nettype none
interface tmoe_pin_if #(parameter int N = 1);
  logic [N-1:0] dat;
  logic [N-1:0] en;
  modport ctl (output dat, output en);
  modport drv (input dat, input en);
endinterface : tmoe_pin_if
`default_nettype wire

// ### hw/tmoe_pin_stage.sv
// Purpose: Registers pin data and output enables of one pin group
// Assumes: Values come from logic on the same clock
// Notes: Resets to released pins, data parked low
`timescale 1ns/10ps
`default_nettype none
module tmoe_pin_stage #(
  parameter int N = 1
) (
  input wire logic i_clk,
  input wire logic i_rst_b,
  tmoe_pin_if.drv pins,
  output logic [N-1:0] o_pin,
  output logic [N-1:0] o_pin_oe
);
  logic [N-1:0] next_pin;
  logic [N-1:0] next_oe;
  genvar g;
  generate
    for (g = 0; g < N; g++) begin : g_pin
      // Low enable releases the pin; data is parked low then
      always_comb begin
        next_oe[g] = pins.en[g];
        next_pin[g] = pins.en[g] & pins.dat[g];
      end
    end
  endgenerate
  always_ff @(posedge i_clk) begin
    if (!i_rst_b) begin
      o_pin <= '0;
      o_pin_oe <= '0;
    end else begin
      o_pin <= next_pin;
      o_pin_oe <= next_oe;
    end
  end
endmodule : tmoe_pin_stage
`default_nettype wire

// ### hw/tmoe_regs.sv
// Purpose: Software reset and timing output enable registers
// Assumes: Parallel port strobes are synchronous to i_clk
// Notes: Enables take effect on the pins two edges after the write
//
// Contract
// - Bit 7 high drives offset pulse one
// - Bit 7 low releases offset pulse one
// - Bit 6 high drives offset pulse zero
// - Bit 6 low releases offset pulse zero
`timescale 1ns/10ps
`default_nettype none
module tmoe_regs (
  input wire logic i_clk,
  input wire logic i_rst_b,
  input wire logic i_sel,
  input wire logic i_wr,
  input wire logic [tmoe_pkg::ADDR_W-1:0] i_addr,
  input wire logic [tmoe_pkg::DATA_W-1:0] i_wdata,
  output logic [tmoe_pkg::DATA_W-1:0] o_rdata,
  output logic o_switch_soft_reset,
  input wire logic [tmoe_pkg::CLK_PULSE_PAIR_CNT-1:0] i_timing_clock,
  input wire logic [tmoe_pkg::CLK_PULSE_PAIR_CNT-1:0] i_frame_pulse,
  input wire logic [tmoe_pkg::OFFSET_PULSE_CNT-1:0] i_offset_pulse,
  output logic [tmoe_pkg::CLK_PULSE_PAIR_CNT-1:0] o_timing_clock_out,
  output logic [tmoe_pkg::CLK_PULSE_PAIR_CNT-1:0] o_timing_clock_out_oe,
  output logic [tmoe_pkg::CLK_PULSE_PAIR_CNT-1:0] o_frame_pulse_out,
  output logic [tmoe_pkg::CLK_PULSE_PAIR_CNT-1:0] o_frame_pulse_out_oe,
  output logic [tmoe_pkg::OFFSET_PULSE_CNT-1:0] o_offset_frame_pulse_out,
  output logic [tmoe_pkg::OFFSET_PULSE_CNT-1:0] o_offset_frame_pulse_out_oe
);
  localparam int NP = tmoe_pkg::CLK_PULSE_PAIR_CNT;
  localparam int NO = tmoe_pkg::OFFSET_PULSE_CNT;

  logic [tmoe_pkg::DATA_W-1:0] software_reset_control;
  logic [tmoe_pkg::DATA_W-1:0] timing_output_enable;
  logic [tmoe_pkg::DATA_W-1:0] next_software_reset_control;
  logic [tmoe_pkg::DATA_W-1:0] next_timing_output_enable;
  logic [tmoe_pkg::DATA_W-1:0] next_rdata;
  logic next_switch_soft_reset;
  logic [NP-1:0] pair_en;
  logic [NO-1:0] offset_en;

  tmoe_pin_if #(.N(NP)) clk_pins ();
  tmoe_pin_if #(.N(NP)) fp_pins ();
  tmoe_pin_if #(.N(NO)) off_pins ();

  // Register write and read path
  always_comb begin
    next_software_reset_control = software_reset_control;
    next_timing_output_enable = timing_output_enable;
    next_rdata = '0;
    if (i_sel && i_wr) begin
      if (i_addr == tmoe_pkg::SW_RESET_CTRL_ADDR) begin
        next_software_reset_control = i_wdata & tmoe_pkg::SW_RESET_CTRL_MASK;
      end
      if (i_addr == tmoe_pkg::TIMING_OUT_EN_ADDR) begin
        next_timing_output_enable = i_wdata & tmoe_pkg::TIMING_OUT_EN_MASK;
      end
    end
    // Unmapped addresses read as zero
    if (i_sel && !i_wr) begin
      if (i_addr == tmoe_pkg::SW_RESET_CTRL_ADDR) begin
        next_rdata = software_reset_control;
      end else if (i_addr == tmoe_pkg::TIMING_OUT_EN_ADDR) begin
        next_rdata = timing_output_enable;
      end
    end
    // Switching blocks stay in reset while the bit is low
    next_switch_soft_reset = ~next_software_reset_control[tmoe_pkg::SWITCH_SOFT_RESET_BIT];
  end

  always_ff @(posedge i_clk) begin
    if (!i_rst_b) begin
      software_reset_control <= tmoe_pkg::SW_RESET_CTRL_RST;
      timing_output_enable <= tmoe_pkg::TIMING_OUT_EN_RST;
      o_rdata <= '0;
      o_switch_soft_reset <= 1'b1;
    end else begin
      software_reset_control <= next_software_reset_control;
      timing_output_enable <= next_timing_output_enable;
      o_rdata <= next_rdata;
      o_switch_soft_reset <= next_switch_soft_reset;
    end
  end

  // Enable field decode
  always_comb begin
    pair_en = timing_output_enable[tmoe_pkg::CLK_PULSE_PAIR0_DRIVE_EN +: NP];
    offset_en[0] = timing_output_enable[tmoe_pkg::OFFSET_PULSE0_DRIVE_EN];
    offset_en[1] = timing_output_enable[tmoe_pkg::OFFSET_PULSE1_DRIVE_EN];
    offset_en[2] = timing_output_enable[tmoe_pkg::OFFSET_PULSE2_DRIVE_EN];
  end

  // one enable covers clock and pulse
  assign clk_pins.dat = i_timing_clock;
  assign clk_pins.en = pair_en;
  assign fp_pins.dat = i_frame_pulse;
  assign fp_pins.en = pair_en;
  assign off_pins.dat = i_offset_pulse;
  assign off_pins.en = offset_en;

  tmoe_pin_stage #(.N(NP)) u_clk_stage (
    .i_clk(i_clk),
    .i_rst_b(i_rst_b),
    .pins(clk_pins.drv),
    .o_pin(o_timing_clock_out),
    .o_pin_oe(o_timing_clock_out_oe)
  );
  tmoe_pin_stage #(.N(NP)) u_fp_stage (
    .i_clk(i_clk),
    .i_rst_b(i_rst_b),
    .pins(fp_pins.drv),
    .o_pin(o_frame_pulse_out),
    .o_pin_oe(o_frame_pulse_out_oe)
  );
  tmoe_pin_stage #(.N(NO)) u_off_stage (
    .i_clk(i_clk),
    .i_rst_b(i_rst_b),
    .pins(off_pins.drv),
    .o_pin(o_offset_frame_pulse_out),
    .o_pin_oe(o_offset_frame_pulse_out_oe)
  );
endmodule : tmoe_regs
`default_nettype wire

// ### bench/tmoe_regs_properties.sv
// Purpose: Pin enable timing checks
// Assumes: Only top ports seen
// Notes: Enables follow a write two edges later
`timescale 1ns/10ps
`default_nettype none
module tmoe_chk (
  input wire logic i_clk, i_rst_b, i_sel, i_wr,
  input wire logic [13:0] i_addr,
  input wire logic [15:0] i_wdata,
  input wire logic [3:0] o_timing_clock_out_oe, o_frame_pulse_out_oe,
  input wire logic [2:0] o_offset_frame_pulse_out_oe
);
  wire w3 = i_sel && i_wr && i_addr == 14'h0003;
  default clocking @(posedge i_clk); endclocking
  default disable iff (!i_rst_b);
  property p_off1_on; w3 && i_wdata[7] |-> ##2 o_offset_frame_pulse_out_oe[1]; endproperty
  a_off1_on: assert property (p_off1_on) else $error("pulse 1 not driven");
  property p_off1_off; w3 && !i_wdata[7] |-> ##2 !o_offset_frame_pulse_out_oe[1]; endproperty
  a_off1_off: assert property (p_off1_off) else $error("pulse 1 driven");
  property p_off0_on; w3 && i_wdata[6] |-> ##2 o_offset_frame_pulse_out_oe[0]; endproperty
  a_off0_on: assert property (p_off0_on) else $error("pulse 0 not driven");
  property p_off0_off; w3 && !i_wdata[6] |-> ##2 !o_offset_frame_pulse_out_oe[0]; endproperty
  a_off0_off: assert property (p_off0_off) else $error("pulse 0 driven");
  property p_pairs;
    w3 |-> ##2 o_timing_clock_out_oe == $past(i_wdata[3:0], 2) && o_frame_pulse_out_oe == o_timing_clock_out_oe
      && o_offset_frame_pulse_out_oe[2] == $past(i_wdata[8], 2);
  endproperty
  a_pairs: assert property (p_pairs) else $error("pair enables wrong");
endmodule : tmoe_chk
bind tmoe_regs tmoe_chk u_chk (.i_clk, .i_rst_b, .i_sel, .i_wr, .i_addr, .i_wdata,
  .o_timing_clock_out_oe, .o_frame_pulse_out_oe, .o_offset_frame_pulse_out_oe);
`default_nettype wire

// ### bench/test_timing_output_enable_regs.sv
// Purpose: Random register traffic against a model
// Assumes: Pin enables lag the register by one edge
// Notes: Addresses 0 and 1 are unmapped
`timescale 1ns/10ps
`default_nettype none
module test_timing_output_enable_regs;
  logic i_clk = 1'h0, i_rst_b = 1'h0, i_sel = 1'h0, i_wr = 1'h0, o_switch_soft_reset;
  logic [13:0] i_addr = '0;
  logic [15:0] i_wdata = '0, o_rdata, m2 = '0, m3 = '0, old3 = '0, exp_rd = '0;
  logic [3:0] i_timing_clock = '0, i_frame_pulse = '0, tc, tco, fp, fpo;
  logic [2:0] i_offset_pulse = '0, op, opo;
  int fail_count = 0, comparisons = 0, seed = 41;
  tmoe_regs uut (.i_clk, .i_rst_b, .i_sel, .i_wr, .i_addr, .i_wdata, .o_rdata, .o_switch_soft_reset,
    .i_timing_clock, .i_frame_pulse, .i_offset_pulse, .o_timing_clock_out(tc), .o_timing_clock_out_oe(tco),
    .o_frame_pulse_out(fp), .o_frame_pulse_out_oe(fpo), .o_offset_frame_pulse_out(op),
    .o_offset_frame_pulse_out_oe(opo));
  initial forever #4 i_clk = ~i_clk;
  task automatic check(input logic [15:0] seen, input logic [15:0] exp);
    comparisons++;
    if (seen !== exp) begin
      fail_count++;
      $display("MISMATCH t=%0t seen=%h exp=%h", $time, seen, exp);
    end
  endtask : check
  task automatic end_sim;
    $display("comparisons=%0d fail_count=%0d", comparisons, fail_count);
    if (fail_count == 0 && comparisons > 0) $display("== PASSED ==");
    else $display("== FAILED ==");
    $finish;
  endtask : end_sim
  initial begin
    #10000;
    fail_count++;
    end_sim();
  end
  initial begin
    repeat (4) @(posedge i_clk);
    #1 i_rst_b = 1'h1;
    repeat (400) begin
      @(posedge i_clk);
      #1;
      check(o_rdata, exp_rd);
      check({opo, fpo, tco}, {old3[8:6], old3[3:0], old3[3:0]});
      check({op & ~opo, fp & ~fpo, tc & ~tco}, 16'h0);
      check({op, fp, tc}, {i_offset_pulse & old3[8:6], i_frame_pulse & old3[3:0], i_timing_clock & old3[3:0]});
      check(o_switch_soft_reset, !m2[1]);
      old3 = m3;
      {i_sel, i_wr} = 2'($random(seed));
      i_addr = 14'($unsigned($random(seed)) % 4);
      {i_wdata, i_timing_clock, i_frame_pulse, i_offset_pulse} = 27'({$random(seed), $random(seed)});
      // Reads see the register before this edge's write
      exp_rd = (i_sel && !i_wr) ? (i_addr == 14'h3 ? m3 : i_addr == 14'h2 ? m2 : 16'h0) : 16'h0;
      if (i_sel && i_wr && i_addr == 14'h3) m3 = i_wdata & 16'h01cf;
      if (i_sel && i_wr && i_addr == 14'h2) m2 = i_wdata & 16'h0002;
    end
    end_sim();
  end
endmodule : test_timing_output_enable_regs
`default_nettype wire
